// file: rtl/ifpd_front_end.sv
// Front end: instruction cache, branch predictors and early decode to three macro-op slots
`timescale 1ns/1ps
module ifpd_front_end #(
	parameter int MISPRED_PENALTY = ifpd_pkg::MISPRED_CYCLES
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Fill requests toward level two
	output logic fill_req_valid_out,
	output logic [ifpd_pkg::ADDR_W-1:0] fill_req_addr_out,
	input wire logic fill_req_ready_in,
	// Fill data from level two
	input wire ifpd_pkg::ifpd_fill_rsp_t fill_rsp_in,
	// Evicted lines toward level two
	output ifpd_pkg::ifpd_evict_t evict_out,
	// Branch outcomes from execution
	input wire ifpd_pkg::ifpd_resolve_t resolve_in,
	// Macro-op groups to the control unit
	output logic mop_valid_out,
	output logic [ifpd_pkg::ISSUE_W-1:0] mop_slot_valid_out,
	output ifpd_pkg::ifpd_mop_t [ifpd_pkg::ISSUE_W-1:0] mop_out,
	input wire logic mop_ready_in
);
	localparam int AW = ifpd_pkg::ADDR_W;
	localparam int OW = ifpd_pkg::OFF_W;
	localparam int SW = ifpd_pkg::SET_W;
	localparam int HW = ifpd_pkg::HIST_W;
	localparam int LB = ifpd_pkg::LINE_BYTES;
	localparam int PEN_W = $clog2(MISPRED_PENALTY + 1);
	localparam logic [PEN_W-1:0] PEN_LOAD = PEN_W'(MISPRED_PENALTY);

	// Cache storage, predecode beside the bytes
	logic [LB*8-1:0] data_mem [ifpd_pkg::SETS][ifpd_pkg::WAYS];
	logic [ifpd_pkg::TAG_W-1:0] tag_mem [ifpd_pkg::SETS][ifpd_pkg::WAYS];
	ifpd_pkg::ifpd_pd_t pd_mem [ifpd_pkg::SETS][ifpd_pkg::WAYS];
	logic [ifpd_pkg::SETS*ifpd_pkg::WAYS-1:0] line_vld_q;
	logic [ifpd_pkg::SETS-1:0] lru_q;
	// Predictor storage
	logic [AW-1:0] btb_pc_mem [ifpd_pkg::BTB_N];
	logic [AW-1:0] btb_tgt_mem [ifpd_pkg::BTB_N];
	logic [ifpd_pkg::BTB_N-1:0] btb_vld_q;
	logic [ifpd_pkg::BTB_N-1:0] btb_phase_q;
	logic [1:0] hist_mem [ifpd_pkg::HIST_N];
	logic [ifpd_pkg::HIST_N-1:0] hist_vld_q;
	logic [AW-1:0] ind_mem [ifpd_pkg::IND_N];
	logic [ifpd_pkg::IND_N-1:0] ind_vld_q;
	logic [AW-1:0] ras_mem [ifpd_pkg::RAS_N];
	logic [ifpd_pkg::RAS_W-1:0] ras_sp_q;
	logic [ifpd_pkg::RAS_W-1:0] ras_cnt_q;
	// Fetch state
	logic [AW-1:0] pc_q;
	logic [HW-1:0] ghr_q;
	logic [PEN_W-1:0] pen_q;
	ifpd_pkg::ifpd_fill_state_t fs_q;
	logic [AW-1:0] miss_addr_q;
	logic miss_done_q;
	logic req_vld_q;
	logic [AW-1:0] req_addr_q;
	ifpd_pkg::ifpd_evict_t evict_q;
	logic mop_vld_q;
	logic [ifpd_pkg::ISSUE_W-1:0] slot_vld_q;
	ifpd_pkg::ifpd_mop_t [ifpd_pkg::ISSUE_W-1:0] mop_q;

	// Fetch-side cache lookup
	logic [SW-1:0] f_set;
	logic [ifpd_pkg::TAG_W-1:0] f_tag;
	logic [ifpd_pkg::WAYS-1:0] way_hit;
	logic f_hit;
	logic f_way;
	logic [LB*8-1:0] f_line;
	ifpd_pkg::ifpd_pd_t f_pd;
	logic [AW-1:0] ras_top;
	logic [31:0] win_lim;
	assign f_set = pc_q[OW +: SW];
	assign f_tag = pc_q[AW-1 -: ifpd_pkg::TAG_W];
	for (genvar w = 0; w < ifpd_pkg::WAYS; w++) begin : g_hit
		assign way_hit[w] = line_vld_q[{f_set, 1'(w)}] && tag_mem[f_set][w] == f_tag;
	end
	assign f_hit = |way_hit;
	assign f_way = way_hit[1];
	assign f_line = data_mem[f_set][f_way];
	assign f_pd = pd_mem[f_set][f_way];
	// Window ends at the next 32-byte boundary
	assign win_lim = pc_q[OW-1] ? 32'(LB) : 32'(ifpd_pkg::WIN_BYTES);
	assign ras_top = ras_mem[ras_sp_q == '0 ? 5'(ifpd_pkg::RAS_N - 1) : ras_sp_q - 5'h1];

	// Fetch may proceed only when nothing holds it off
	logic flush_w;
	logic go_w;
	logic miss_w;
	assign flush_w = resolve_in.valid && resolve_in.mispredict;
	assign go_w = fs_q == ifpd_pkg::FS_IDLE && pen_q == '0 && f_hit && !flush_w
		&& (!mop_vld_q || mop_ready_in);
	assign miss_w = fs_q == ifpd_pkg::FS_IDLE && pen_q == '0 && !f_hit && !flush_w;

	// Early decode and same-cycle prediction of up to three instructions
	ifpd_pkg::ifpd_mop_t [ifpd_pkg::ISSUE_W-1:0] dec_mop;
	logic [ifpd_pkg::ISSUE_W-1:0] dec_vld;
	logic [AW-1:0] dec_next_pc;
	logic [AW-1:0] dec_ret_addr;
	logic dec_cond;
	logic dec_pred;
	logic dec_call;
	logic dec_ret;
	always_comb begin
		int off;
		logic stop;
		logic [7:0] op;
		logic [2:0] ln;
		ifpd_pkg::ifpd_kind_t k;
		logic [AW-1:0] bpc;
		logic [ifpd_pkg::BTB_W-1:0] bi;
		logic [HW-1:0] hi;
		logic [ifpd_pkg::IND_W-1:0] ii;
		logic bh;
		logic [1:0] ctr;
		logic pt;
		logic [AW-1:0] tg;
		off = int'(pc_q[OW-1:0]);
		stop = 1'b0;
		op = '0;
		ln = '0;
		k = ifpd_pkg::IFPD_PLAIN;
		bpc = '0;
		bi = '0;
		hi = '0;
		ii = '0;
		bh = 1'b0;
		ctr = '0;
		pt = 1'b0;
		tg = '0;
		dec_mop = '0;
		dec_vld = '0;
		dec_next_pc = pc_q;
		dec_ret_addr = pc_q;
		dec_cond = 1'b0;
		dec_pred = 1'b0;
		dec_call = 1'b0;
		dec_ret = 1'b0;
		for (int i = 0; i < ifpd_pkg::ISSUE_W; i++) begin
			op = f_line[(off % LB) * 8 +: 8];
			ln = {1'b0, f_pd.len[(off % LB) * 2 +: 2]} + 3'h1;
			k = ifpd_pkg::ifpd_kind_t'(op[7:5]);
			bpc = {pc_q[AW-1:OW], OW'(off % LB)};
			// Microcoded op past slot 0 waits for its own cycle
			if (k == ifpd_pkg::IFPD_MICRO && i != 0) begin
				stop = 1'b1;
			end
			if (!stop && off < int'(win_lim)) begin
				dec_vld[i] = 1'b1;
				dec_mop[i].pc = bpc;
				dec_mop[i].opcode = op;
				dec_mop[i].len = ln;
				dec_mop[i].kind = k;
				dec_mop[i].ghr = ghr_q;
				dec_next_pc = bpc + AW'(ln);
				dec_ret_addr = bpc + AW'(ln);
				off = off + int'(ln);
				bi = bpc[ifpd_pkg::BTB_W-1:0];
				hi = bpc[HW-1:0] ^ ghr_q;
				ii = bpc[ifpd_pkg::IND_W-1:0] ^ ghr_q[ifpd_pkg::IND_W-1:0];
				bh = btb_vld_q[bi] && btb_pc_mem[bi] == bpc;
				ctr = hist_vld_q[hi] ? hist_mem[hi] : ifpd_pkg::CTR_INIT;
				pt = 1'b0;
				tg = btb_tgt_mem[bi];
				unique case (k)
					ifpd_pkg::IFPD_COND: begin
						pt = bh && (!btb_phase_q[bi] || ctr[1]);
						dec_cond = 1'b1;
						dec_pred = pt;
					end
					ifpd_pkg::IFPD_JUMP,
					ifpd_pkg::IFPD_CALL: pt = bh;
					ifpd_pkg::IFPD_RET: begin
						pt = ras_cnt_q != '0;
						tg = ras_top;
					end
					ifpd_pkg::IFPD_IND: begin
						pt = bh || ind_vld_q[ii];
						tg = ind_vld_q[ii] ? ind_mem[ii] : btb_tgt_mem[bi];
					end
					ifpd_pkg::IFPD_MICRO: begin
						// Microcoded op fills all three slots itself
						for (int j = 0; j < ifpd_pkg::ISSUE_W; j++) begin
							dec_vld[j] = 1'b1;
							dec_mop[j] = dec_mop[0];
							dec_mop[j].step = 2'(j);
						end
						stop = 1'b1;
					end
					default: pt = 1'b0;
				endcase
				// One branch per group keeps history and stack simple
				if (k inside {[ifpd_pkg::IFPD_COND : ifpd_pkg::IFPD_IND]}) begin
					stop = 1'b1;
					dec_call = k == ifpd_pkg::IFPD_CALL;
					dec_ret = k == ifpd_pkg::IFPD_RET;
					dec_mop[i].pred_taken = pt;
					dec_mop[i].pred_target = pt ? tg : '0;
					if (pt) begin
						dec_next_pc = tg;
					end
				end
			end
		end
	end

	// Resolution side decode for predictor training
	logic [ifpd_pkg::BTB_W-1:0] r_bi;
	logic [HW-1:0] r_hi;
	logic [ifpd_pkg::IND_W-1:0] r_ii;
	logic r_bh;
	logic r_br;
	logic r_cond;
	logic [1:0] r_ctr;
	logic [1:0] r_ctr_nxt;
	logic r_alloc;
	logic r_to_table;
	logic r_train;
	assign r_bi = resolve_in.pc[ifpd_pkg::BTB_W-1:0];
	assign r_hi = resolve_in.pc[HW-1:0] ^ resolve_in.ghr;
	assign r_ii = resolve_in.pc[ifpd_pkg::IND_W-1:0] ^ resolve_in.ghr[ifpd_pkg::IND_W-1:0];
	assign r_bh = btb_vld_q[r_bi] && btb_pc_mem[r_bi] == resolve_in.pc;
	assign r_br = resolve_in.valid && resolve_in.kind inside {[ifpd_pkg::IFPD_COND :
		ifpd_pkg::IFPD_IND]} && resolve_in.kind != ifpd_pkg::IFPD_RET;
	assign r_cond = r_br && resolve_in.kind == ifpd_pkg::IFPD_COND;
	assign r_ctr = hist_vld_q[r_hi] ? hist_mem[r_hi] : ifpd_pkg::CTR_INIT;
	assign r_ctr_nxt = resolve_in.taken ? (r_ctr == 2'h3 ? 2'h3 : r_ctr + 2'h1)
		: (r_ctr == 2'h0 ? 2'h0 : r_ctr - 2'h1);
	assign r_alloc = r_br && resolve_in.taken;
	assign r_to_table = r_cond && r_bh && !btb_phase_q[r_bi] && !resolve_in.taken;
	assign r_train = r_cond && r_bh && btb_phase_q[r_bi];

	// Predictor array writes; valid bits carry the reset
	always_ff @(posedge clk_in) begin
		if (r_alloc) begin
			btb_pc_mem[r_bi] <= resolve_in.pc;
			btb_tgt_mem[r_bi] <= resolve_in.target;
		end
		if (r_to_table || r_train) begin
			hist_mem[r_hi] <= r_train ? r_ctr_nxt : ifpd_pkg::CTR_INIT;
		end
		if (r_alloc && resolve_in.kind == ifpd_pkg::IFPD_IND) begin
			ind_mem[r_ii] <= resolve_in.target;
		end
	end

	// Predictor valid and phase bits
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			btb_vld_q <= '0;
			btb_phase_q <= '0;
			hist_vld_q <= '0;
			ind_vld_q <= '0;
		end else begin
			if (r_alloc) begin
				btb_vld_q[r_bi] <= 1'b1;
				btb_phase_q[r_bi] <= r_bh && btb_phase_q[r_bi];
			end
			if (r_to_table) begin
				btb_phase_q[r_bi] <= 1'b1;
			end
			if (r_to_table || r_train) begin
				hist_vld_q[r_hi] <= 1'b1;
			end
			if (r_alloc && resolve_in.kind == ifpd_pkg::IFPD_IND) begin
				ind_vld_q[r_ii] <= 1'b1;
			end
		end
	end

	// Return stack pointer; no repair after a flush, a known limitation
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			ras_sp_q <= '0;
			ras_cnt_q <= '0;
		end else if (go_w && dec_call) begin
			ras_sp_q <= ras_sp_q == 5'(ifpd_pkg::RAS_N - 1) ? '0 : ras_sp_q + 5'h1;
			ras_cnt_q <= ras_cnt_q == 5'(ifpd_pkg::RAS_N) ? ras_cnt_q : ras_cnt_q + 5'h1;
		end else if (go_w && dec_ret && ras_cnt_q != '0) begin
			ras_sp_q <= ras_sp_q == '0 ? 5'(ifpd_pkg::RAS_N - 1) : ras_sp_q - 5'h1;
			ras_cnt_q <= ras_cnt_q - 5'h1;
		end
	end

	// Return address storage
	always_ff @(posedge clk_in) begin
		if (go_w && dec_call) begin
			ras_mem[ras_sp_q] <= dec_ret_addr;
		end
	end

	// Program counter, history and misprediction hold-off
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			pc_q <= ifpd_pkg::RESET_PC;
			ghr_q <= '0;
			pen_q <= '0;
		end else if (flush_w) begin
			pc_q <= resolve_in.next_pc;
			pen_q <= PEN_LOAD;
			ghr_q <= resolve_in.kind == ifpd_pkg::IFPD_COND
				? {resolve_in.ghr[HW-2:0], resolve_in.taken} : resolve_in.ghr;
		end else begin
			pen_q <= pen_q == '0 ? pen_q : pen_q - PEN_W'(1);
			if (go_w) begin
				pc_q <= dec_next_pc;
				ghr_q <= dec_cond ? {ghr_q[HW-2:0], dec_pred} : ghr_q;
			end
		end
	end

	// Macro-op group register toward the control unit
	always_ff @(posedge clk_in) begin
		if (reset_in || flush_w) begin
			mop_vld_q <= 1'b0;
			slot_vld_q <= '0;
			mop_q <= '0;
		end else if (go_w) begin
			mop_vld_q <= 1'b1;
			slot_vld_q <= dec_vld;
			mop_q <= dec_mop;
		end else if (mop_ready_in) begin
			mop_vld_q <= 1'b0;
		end
	end

	// Fill request sequencer: missed line, then its successor
	logic rsp_miss;
	assign rsp_miss = fill_rsp_in.valid && fill_rsp_in.addr[AW-1:OW] == miss_addr_q[AW-1:OW];
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			fs_q <= ifpd_pkg::FS_IDLE;
			req_vld_q <= 1'b0;
			req_addr_q <= '0;
			miss_addr_q <= '0;
			miss_done_q <= 1'b0;
		end else begin
			if (rsp_miss) begin
				miss_done_q <= 1'b1;
			end
			unique case (fs_q)
				ifpd_pkg::FS_IDLE: if (miss_w) begin
					miss_addr_q <= {pc_q[AW-1:OW], OW'(0)};
					req_addr_q <= {pc_q[AW-1:OW], OW'(0)};
					req_vld_q <= 1'b1;
					miss_done_q <= 1'b0;
					fs_q <= ifpd_pkg::FS_REQ_MISS;
				end
				ifpd_pkg::FS_REQ_MISS: if (fill_req_ready_in) begin
					req_addr_q <= miss_addr_q + AW'(LB);
					fs_q <= ifpd_pkg::FS_REQ_PREF;
				end
				ifpd_pkg::FS_REQ_PREF: if (fill_req_ready_in) begin
					req_vld_q <= 1'b0;
					fs_q <= ifpd_pkg::FS_WAIT;
				end
				ifpd_pkg::FS_WAIT: if (miss_done_q || rsp_miss) begin
					fs_q <= ifpd_pkg::FS_IDLE;
				end
			endcase
		end
	end

	// Fill side: predecode walk and victim choice
	logic [SW-1:0] r_set;
	logic [ifpd_pkg::WAYS-1:0] dup_hit;
	logic [ifpd_pkg::WAYS-1:0] vld_pair;
	logic vw;
	ifpd_pkg::ifpd_pd_t pd_w;
	assign r_set = fill_rsp_in.addr[OW +: SW];
	for (genvar w = 0; w < ifpd_pkg::WAYS; w++) begin : g_dup
		assign vld_pair[w] = line_vld_q[{r_set, 1'(w)}];
		assign dup_hit[w] = vld_pair[w]
			&& tag_mem[r_set][w] == fill_rsp_in.addr[AW-1 -: ifpd_pkg::TAG_W];
	end
	assign vw = |dup_hit ? dup_hit[1] : !vld_pair[0] ? 1'b0 : !vld_pair[1] ? 1'b1
		: lru_q[r_set];
	always_comb begin
		int nxt;
		logic [2:0] kb;
		nxt = 0;
		kb = '0;
		pd_w = '0;
		for (int i = 0; i < LB; i++) begin
			pd_w.len[i*2 +: 2] = fill_rsp_in.data[i*8 +: 2];
			pd_w.start[i] = i == nxt;
			kb = fill_rsp_in.data[i*8+5 +: 3];
			pd_w.sel[i] = pd_w.start[i] && kb >= 3'h1 && kb <= 3'h5;
			if (pd_w.start[i]) begin
				nxt = i + int'(fill_rsp_in.data[i*8 +: 2]) + 1;
			end
		end
	end

	// Line storage writes
	always_ff @(posedge clk_in) begin
		if (fill_rsp_in.valid) begin
			data_mem[r_set][vw] <= fill_rsp_in.data;
			tag_mem[r_set][vw] <= fill_rsp_in.addr[AW-1 -: ifpd_pkg::TAG_W];
			pd_mem[r_set][vw] <= pd_w;
		end
	end

	// Line valid and recency; a fill outranks a hit on the same set
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			line_vld_q <= '0;
			lru_q <= '0;
		end else begin
			if (go_w) begin
				lru_q[f_set] <= !f_way;
			end
			if (fill_rsp_in.valid) begin
				line_vld_q[{r_set, vw}] <= 1'b1;
				lru_q[r_set] <= !vw;
			end
		end
	end

	// Victim leaves with bytes, predecode and selectors
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			evict_q <= '0;
		end else begin
			evict_q.valid <= fill_rsp_in.valid && vld_pair[vw] && !(|dup_hit);
			evict_q.addr <= {tag_mem[r_set][vw], r_set, OW'(0)};
			evict_q.data <= data_mem[r_set][vw];
			evict_q.pd <= pd_mem[r_set][vw];
		end
	end

	// Outputs straight from registers
	assign fill_req_valid_out = req_vld_q;
	assign fill_req_addr_out = req_addr_q;
	assign evict_out = evict_q;
	assign mop_valid_out = mop_vld_q;
	assign mop_slot_valid_out = slot_vld_q;
	assign mop_out = mop_q;
endmodule // ifpd_front_end

// file: rtl/ifpd_pkg.sv
// Shared constants and carrier types for the instruction fetch, predict and decode front end
package ifpd_pkg;
	localparam int ADDR_W = 32;
	localparam int LINE_BYTES = 64;
	localparam int OFF_W = 6;
	localparam int WAYS = 2;
	localparam int CACHE_BYTES = 65536;
	localparam int SETS = CACHE_BYTES / (LINE_BYTES * WAYS);
	localparam int SET_W = 9;
	localparam int TAG_W = ADDR_W - SET_W - OFF_W;
	localparam int WIN_BYTES = 32;
	localparam int ISSUE_W = 3;
	localparam int BTB_N = 2048;
	localparam int BTB_W = 11;
	localparam int HIST_N = 16384;
	localparam int HIST_W = 14;
	localparam int IND_N = 512;
	localparam int IND_W = 9;
	localparam int RAS_N = 24;
	localparam int RAS_W = 5;
	localparam int MISPRED_CYCLES = 10;
	localparam logic [1:0] CTR_INIT = 2'h1;
	localparam logic [ADDR_W-1:0] RESET_PC = 32'h0000_0000;

	// Instruction class is the top three opcode bits
	typedef enum logic [2:0] {
		IFPD_PLAIN, IFPD_COND, IFPD_JUMP, IFPD_CALL, IFPD_RET, IFPD_IND, IFPD_MICRO, IFPD_RSVD
	} ifpd_kind_t;

	typedef enum logic [1:0] {FS_IDLE, FS_REQ_MISS, FS_REQ_PREF, FS_WAIT} ifpd_fill_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] pc;
		logic [7:0] opcode;
		logic [2:0] len;
		ifpd_kind_t kind;
		logic [1:0] step;
		logic pred_taken;
		logic [ADDR_W-1:0] pred_target;
		logic [HIST_W-1:0] ghr;
	} ifpd_mop_t;

	typedef struct packed {
		logic [LINE_BYTES-1:0] start;
		logic [LINE_BYTES*2-1:0] len;
		logic [LINE_BYTES-1:0] sel;
	} ifpd_pd_t;

	typedef struct packed {
		logic valid;
		logic [ADDR_W-1:0] addr;
		logic [LINE_BYTES*8-1:0] data;
	} ifpd_fill_rsp_t;

	typedef struct packed {
		logic valid;
		logic [ADDR_W-1:0] addr;
		logic [LINE_BYTES*8-1:0] data;
		ifpd_pd_t pd;
	} ifpd_evict_t;

	typedef struct packed {
		logic valid;
		logic mispredict;
		logic [ADDR_W-1:0] pc;
		ifpd_kind_t kind;
		logic taken;
		logic [ADDR_W-1:0] target;
		logic [ADDR_W-1:0] next_pc;
		logic [HIST_W-1:0] ghr;
	} ifpd_resolve_t;
endpackage

// file: sim/ifpd_front_end_bench.sv
// Self-checking bench for the front end
`timescale 1ns/1ps
module ifpd_front_end_bench;
	localparam int PEN = 10;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic req_v;
	logic req_r;
	logic mop_v;
	logic mop_r = 1'b1;
	logic slow = 1'b0;
	logic [31:0] req_a;
	logic [2:0] sv;
	logic [2:0] gs;
	logic [13:0] ghr = '0;
	ifpd_pkg::ifpd_fill_rsp_t rsp;
	ifpd_pkg::ifpd_evict_t ev;
	ifpd_pkg::ifpd_resolve_t res = '0;
	ifpd_pkg::ifpd_mop_t [2:0] mop;
	ifpd_pkg::ifpd_mop_t [2:0] g;
	logic [31:0] ev_a [$];
	logic [7:0] ev_b [$];
	logic [1:0] ev_l [$];
	int err_count = 0;
	int check_count = 0;
	int cyc;
	always #20 clk_in = ~clk_in;
	ifpd_front_end #(.MISPRED_PENALTY(PEN)) ifpd_front_end_i (.clk_in(clk_in),
		.reset_in(reset_in), .fill_req_valid_out(req_v), .fill_req_addr_out(req_a),
		.fill_req_ready_in(req_r), .fill_rsp_in(rsp), .evict_out(ev), .resolve_in(res),
		.mop_valid_out(mop_v), .mop_slot_valid_out(sv), .mop_out(mop), .mop_ready_in(mop_r));
	ifpd_l2_model ifpd_l2_model_i (.clk_in(clk_in), .reset_in(reset_in), .slow_in(slow),
		.req_valid_in(req_v), .req_addr_in(req_a), .req_ready_out(req_r), .rsp_out(rsp));
	// Keep marker bytes of every evicted line; mid-cycle sees each pulse once
	always @(negedge clk_in) begin
		if (ev.valid === 1'b1) begin
			ev_a.push_back(ev.addr);
			ev_b.push_back(ev.data[71:64]);
			ev_l.push_back(ev.pd.len[121:120]);
		end
	end
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Next group shown to the control unit, bounded wait
	task automatic next_group();
		cyc = 0;
		do begin
			@(negedge clk_in);
			cyc++;
		end while (mop_v !== 1'b1 && cyc < 400);
		check("group shown", 32'h1, 32'(mop_v));
		g = mop;
		gs = sv;
	endtask
	task automatic flush(input ifpd_pkg::ifpd_kind_t k, input logic [31:0] pc, tgt, nxt,
		input logic tk);
		@(negedge clk_in);
		res = '{1'b1, 1'b1, pc, k, tk, tgt, nxt, ghr};
		@(negedge clk_in);
		res.valid = 1'b0;
	endtask
	// Steer fetch anywhere by flushing on a plain op
	task automatic go(input logic [31:0] a);
		flush(ifpd_pkg::IFPD_PLAIN, a, a, a, 1'b0);
		next_group();
	endtask
	task automatic test_cold();
		next_group();
		check("miss line", 32'h0, ifpd_l2_model_i.log_q[0]);
		check("prefetch line", 32'h0000_0040, ifpd_l2_model_i.log_q[1]);
		check("resume pc", 32'h0, g[0].pc);
		check("slots", 32'h7, gs);
		check("slot 2 pc", 32'h2, g[2].pc);
		mop_r = 1'b0;
		repeat (6) @(negedge clk_in);
		check("held pc", 32'h0, mop[0].pc);
		check("held valid", 32'h1, 32'(mop_v));
		mop_r = 1'b1;
		$display("cold start test done");
	endtask
	task automatic test_branch();
		go(32'h6);
		check("cond kind", ifpd_pkg::IFPD_COND, g[2].kind);
		check("first guess", 32'h0, g[2].pred_taken);
		ghr = g[2].ghr;
		flush(ifpd_pkg::IFPD_COND, 32'h8, 32'h30, 32'h30, 1'b1);
		next_group();
		check("penalty", PEN + 1, cyc);
		check("target pc", 32'h30, g[0].pc);
		go(32'h6);
		check("second guess", 32'h1, g[2].pred_taken);
		check("buffer target", 32'h30, g[2].pred_target);
		ghr = g[2].ghr;
		next_group();
		check("redirect delay", 32'h1, cyc);
		check("redirect pc", 32'h30, g[0].pc);
		flush(ifpd_pkg::IFPD_COND, 32'h8, 32'h30, 32'h9, 1'b0);
		go(32'h6);
		check("table guess", 32'h0, g[2].pred_taken);
		$display("branch test done");
	endtask
	task automatic test_call();
		go(32'h18);
		check("call alone", 32'h1, gs);
		next_group();
		check("return pc", 32'h19, g[0].pc);
		check("return target", 32'h19, g[0].pred_target);
		go(32'h28);
		check("micro slots", 32'h7, gs);
		check("micro step", 32'h2, g[2].step);
		$display("call and micro test done");
	endtask
	task automatic test_evict();
		int k;
		k = -1;
		slow = 1'b1;
		go(32'h0000_8000);
		check("far pc", 32'h0000_8000, g[0].pc);
		go(32'h0001_0000);
		check("third pc", 32'h0001_0000, g[0].pc);
		slow = 1'b0;
		foreach (ev_a[i]) begin
			if (ev_a[i] === 32'h0) k = i;
		end
		check("oldest line out", 32'h1, 32'(k >= 0));
		if (k >= 0) begin
			check("evicted byte", 32'h20, ev_b[k]);
			check("evicted length", 32'h3, ev_l[k]);
		end
		$display("eviction test done");
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Code image: plain one-byte ops apart from a few marked bytes
	initial begin
		for (int i = 0; i < 4096; i++) ifpd_l2_model_i.mem[i] = 8'h00;
		ifpd_l2_model_i.mem[8] = 8'h20;
		ifpd_l2_model_i.mem[24] = 8'h60;
		ifpd_l2_model_i.mem[25] = 8'h80;
		ifpd_l2_model_i.mem[40] = 8'hc0;
		ifpd_l2_model_i.mem[60] = 8'h03;
		repeat (10) @(negedge clk_in);
		reset_in = 1'b0;
		test_cold();
		test_branch();
		test_call();
		test_evict();
		final_report();
	end
	// Watchdog far beyond the few hundred cycles needed
	initial begin
		#800_000;
		err_count++;
		$display("watchdog expired");
		final_report();
	end
endmodule // ifpd_front_end_bench

// file: sim/ifpd_front_end_props.sv
// Port checker for the front end
`timescale 1ns/1ps
module ifpd_front_end_props #(parameter int MISPRED_PENALTY = 10) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Watched ports
	input wire logic fill_req_valid_out,
	input wire logic [ifpd_pkg::ADDR_W-1:0] fill_req_addr_out,
	input wire logic fill_req_ready_in,
	input wire ifpd_pkg::ifpd_fill_rsp_t fill_rsp_in,
	input wire ifpd_pkg::ifpd_evict_t evict_out,
	input wire ifpd_pkg::ifpd_resolve_t resolve_in,
	input wire logic mop_valid_out,
	input wire logic [ifpd_pkg::ISSUE_W-1:0] mop_slot_valid_out,
	input wire ifpd_pkg::ifpd_mop_t [ifpd_pkg::ISSUE_W-1:0] mop_out,
	input wire logic mop_ready_in
);
	logic pair_q;
	logic [7:0] pen_q;
	logic take_w;
	logic flush_w;
	logic micro_w;
	logic [2:0] tk_w;
	logic [31:0] tgt_w;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (reset_in);
	// Takes, flushes and the slot with a taken guess (a branch ends its group)
	assign take_w = fill_req_valid_out && fill_req_ready_in;
	assign flush_w = resolve_in.valid && resolve_in.mispredict;
	assign micro_w = mop_out[0].kind == ifpd_pkg::IFPD_MICRO;
	assign tk_w = mop_slot_valid_out & {mop_out[2].pred_taken, mop_out[1].pred_taken,
		mop_out[0].pred_taken};
	assign tgt_w = tk_w[0] ? mop_out[0].pred_target :
		(tk_w[1] ? mop_out[1].pred_target : mop_out[2].pred_target);
	// Second-of-pair flag and penalty window; a new flush restarts the window
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			pair_q <= 1'b0;
			pen_q <= 8'h00;
		end else begin
			pair_q <= pair_q ^ take_w;
			if (flush_w) begin
				pen_q <= 8'(MISPRED_PENALTY + 1);
			end else if (pen_q != 8'h00) begin
				pen_q <= pen_q - 8'h01;
			end
		end
	end
	property p_stand;
		fill_req_valid_out && !fill_req_ready_in |=>
			fill_req_valid_out && $stable(fill_req_addr_out);
	endproperty
	a_stand: assert property (p_stand) else $error("request moved before taken");
	property p_pref;
		take_w && !pair_q |=> fill_req_valid_out &&
			fill_req_addr_out == $past(fill_req_addr_out) + 32'h0000_0040;
	endproperty
	a_pref: assert property (p_pref) else $error("no next-line prefetch");
	property p_evict;
		evict_out.valid |-> $past(fill_rsp_in.valid) && evict_out.addr[5:0] == 6'h00;
	endproperty
	a_evict: assert property (p_evict) else $error("eviction without fill");
	property p_hold;
		mop_valid_out && !mop_ready_in && !flush_w |=> mop_valid_out &&
			$stable(mop_out) && $stable(mop_slot_valid_out);
	endproperty
	a_hold: assert property (p_hold) else $error("group changed while stalled");
	property p_order;
		mop_valid_out && !micro_w |->
			(!mop_slot_valid_out[1] || mop_out[1].pc == mop_out[0].pc + 32'(mop_out[0].len)) &&
			(!mop_slot_valid_out[2] || mop_out[2].pc == mop_out[1].pc + 32'(mop_out[1].len));
	endproperty
	a_order: assert property (p_order) else $error("slots out of order");
	property p_micro;
		mop_valid_out && micro_w |-> mop_slot_valid_out == 3'h7 &&
			mop_out[0].step == 2'h0 && mop_out[1].step == 2'h1 && mop_out[2].step == 2'h2;
	endproperty
	a_micro: assert property (p_micro) else $error("microcoded group malformed");
	property p_pen;
		pen_q != 8'h00 |-> !mop_valid_out;
	endproperty
	a_pen: assert property (p_pen) else $error("group inside penalty");
	property p_redir;
		mop_valid_out && mop_ready_in && (|tk_w) && !flush_w |=>
			!mop_valid_out || mop_out[0].pc == $past(tgt_w);
	endproperty
	a_redir: assert property (p_redir) else $error("taken guess not followed");
	c_pair: cover property (take_w && pair_q);
	c_micro: cover property (mop_valid_out && micro_w);
	c_evict: cover property (evict_out.valid);
endmodule // ifpd_front_end_props

bind ifpd_front_end ifpd_front_end_props #(.MISPRED_PENALTY(MISPRED_PENALTY))
	ifpd_front_end_props_i (.clk_in(clk_in), .reset_in(reset_in),
	.fill_req_valid_out(fill_req_valid_out), .fill_req_addr_out(fill_req_addr_out),
	.fill_req_ready_in(fill_req_ready_in), .fill_rsp_in(fill_rsp_in),
	.evict_out(evict_out), .resolve_in(resolve_in), .mop_valid_out(mop_valid_out),
	.mop_slot_valid_out(mop_slot_valid_out), .mop_out(mop_out), .mop_ready_in(mop_ready_in));

// file: sim/ifpd_l2_model.sv
// Level-two cache model serving line fills
`timescale 1ns/1ps
module ifpd_l2_model #(parameter int LAT = 3) (
	// Clock, reset and pacing
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic slow_in,
	// Fill request and response
	input wire logic req_valid_in,
	input wire logic [31:0] req_addr_in,
	output logic req_ready_out,
	output ifpd_pkg::ifpd_fill_rsp_t rsp_out
);
	logic [7:0] mem [0:4095];
	logic [31:0] pend [$];
	logic [31:0] log_q [$];
	int age = 0;
	initial begin
		req_ready_out = 1'b0;
		rsp_out = '0;
	end
	// In-order answers; slow mode halves ready and stretches latency
	always @(posedge clk_in) begin
		rsp_out.valid <= 1'b0;
		rsp_out.addr <= ~rsp_out.addr;
		rsp_out.data <= ~rsp_out.data;
		req_ready_out <= !reset_in && (!slow_in || !req_ready_out);
		if (reset_in) begin
			pend.delete();
		end else begin
			if (req_valid_in && req_ready_out) begin
				pend.push_back(req_addr_in);
				log_q.push_back(req_addr_in);
			end
			if (pend.size() > 0 && age >= (slow_in ? 4 * LAT : LAT)) begin
				rsp_out.valid <= 1'b1;
				rsp_out.addr <= pend[0];
				for (int i = 0; i < 64; i++) begin
					rsp_out.data[8*i+:8] <= mem[{pend[0][11:6], 6'(i)}];
				end
				void'(pend.pop_front());
				age = 0;
			end else if (pend.size() > 0) begin
				age++;
			end
		end
	end
endmodule // ifpd_l2_model
